/* rtl/cpm_pkg.sv */
// Purpose: constants for the core programming-model state block
// Assumes: 32-bit data, 5-bit register numbers, byte addressing
// Notes: system control register numbers are register indices
package cpm_pkg;
  localparam int unsigned CPM_WORD_W = 32;
  localparam int unsigned CPM_HALF_W = 16;
  localparam int unsigned CPM_BYTE_W = 8;
  localparam int unsigned CPM_NREG = 32;
  localparam logic [4:0] CPM_ZERO_REG = 5'h00;
  localparam logic [4:0] CPM_LINK_REG = 5'h1F;
  // system control register numbers
  localparam logic [4:0] CPM_SC_TLB_PTR_PROG = 5'h00;
  localparam logic [4:0] CPM_SC_TLB_PTR_RAND = 5'h01;
  localparam logic [4:0] CPM_SC_TLB_LO = 5'h02;
  localparam logic [4:0] CPM_SC_HW_OPTIONS = 5'h03;
  localparam logic [4:0] CPM_SC_PAGE_TBL = 5'h04;
  localparam logic [4:0] CPM_SC_FAULT_VA = 5'h08;
  localparam logic [4:0] CPM_SC_TLB_HI = 5'h0A;
  localparam logic [4:0] CPM_SC_STATE_CTRL = 5'h0C;
  localparam logic [4:0] CPM_SC_EXC_REASON = 5'h0D;
  localparam logic [4:0] CPM_SC_EXC_PC = 5'h0E;
  localparam logic [4:0] CPM_SC_REV_ID = 5'h0F;
  // processor_state_control fields
  localparam int unsigned CPM_SR_KU_CUR = 1;
  localparam int unsigned CPM_SR_KU_PREV = 3;
  localparam int unsigned CPM_SR_CU_LO = 28;
  localparam int unsigned CPM_SR_RE = 25;
  localparam logic [31:0] CPM_SR_RESET = 32'h0000_0000;
  // last_exception_reason fields
  localparam int unsigned CPM_EXC_CODE_LO = 2;
  localparam logic [4:0] CPM_EXC_ADDR_LOAD = 5'h04;
  localparam logic [4:0] CPM_EXC_ADDR_STORE = 5'h05;
  localparam logic [4:0] CPM_EXC_COP_UNUSABLE = 5'h0B;
  localparam logic [31:0] CPM_WORD_RESET = 32'h0000_0000;
  // random pointer range, upper bits of the field
  localparam int unsigned CPM_RAND_LO = 8;
  localparam logic [5:0] CPM_RAND_TOP = 6'h3F;
  localparam logic [5:0] CPM_RAND_BOT = 6'h08;
  // user segment: addresses with top bit clear
  localparam int unsigned CPM_SEG_BIT = 31;
  // access sizes
  typedef enum logic [2:0] {
    CPM_SZ_BYTE, CPM_SZ_HALF, CPM_SZ_WORD, CPM_SZ_PART_HIGH, CPM_SZ_PART_LOW
  } cpm_size_e;
endpackage

/* rtl/cpm_state.sv */
// Purpose: architectural state of a 32-bit load/store core
// Assumes: one instruction retires per cycle; decoder drives the strobes
// Notes: no instruction decode or pipeline here, only state and lanes
`timescale 1ns/1ps

module cpm_state
  import cpm_pkg::*;
#(
  parameter bit HAS_FPU = 1'b1,
  parameter logic [31:0] REV_ID = 32'h0000_0A5A // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic big_endian_strap,
  // general register ports
  input wire logic [4:0] rd_a_sel,
  input wire logic [4:0] rd_b_sel,
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data,
  input wire logic wr_en,
  input wire logic [4:0] wr_sel,
  input wire logic [31:0] wr_data,
  input wire logic link_en,
  input wire logic [31:0] link_addr,
  // multiply / divide results
  input wire logic muldiv_en,
  input wire logic [31:0] muldiv_upper,
  input wire logic [31:0] muldiv_lower,
  input wire logic result_upper_wr,
  input wire logic result_lower_wr,
  output logic [31:0] result_upper,
  output logic [31:0] result_lower,
  // memory access lane steering
  input wire logic mem_req,
  input wire logic mem_store,
  input wire logic [2:0] mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_store_reg,
  input wire logic [31:0] mem_load_word,
  input wire logic [31:0] mem_load_old,
  output logic mem_go,
  output logic [3:0] mem_lanes,
  output logic [31:0] mem_store_word,
  output logic [31:0] mem_load_result,
  // coprocessor access
  input wire logic [1:0] cop_sel,
  input wire logic cop_req,
  // system control coprocessor moves
  input wire logic sc_wr,
  input wire logic sc_rd,
  input wire logic [4:0] sc_sel,
  input wire logic [31:0] sc_wdata,
  output logic [31:0] sc_rdata,
  output logic sc_reserved,
  // exceptions
  input wire logic exc_in,
  input wire logic [4:0] exc_code_in,
  input wire logic [31:0] exc_pc,
  input wire logic return_from_exception,
  output logic exc_raise,
  output logic [4:0] exc_raise_code,
  output logic kernel_mode,
  output logic big_endian_now
);

  cpm_size_e sz;
  logic [31:0] regs_q [1:31];
  logic [31:0] hi_q, lo_q;
  logic [31:0] tlb_prog_q, tlb_lo_q, tlb_hi_q, hwopt_q, page_tbl_q;
  logic [31:0] fault_va_q, sr_q, reason_q, epc_q;
  logic [5:0] rand_q;
  logic be_reset_q, strap_seen_q;
  logic [1:0] off;
  logic misaligned, seg_fault, cop_fault, fault, user_cur, lane_big, lane_bit;

  // strap is caught by a clocked process on the first edge after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      be_reset_q <= 1'b1;
      strap_seen_q <= 1'b0;
    end else if (!strap_seen_q) begin
      be_reset_q <= big_endian_strap;
      strap_seen_q <= 1'b1;
    end
  end

  assign user_cur = sr_q[CPM_SR_KU_CUR];
  assign kernel_mode = !user_cur;
  // reversed order applies only while running in user mode
  assign lane_big = be_reset_q ^ (user_cur & sr_q[CPM_SR_RE]);
  assign big_endian_now = lane_big;
  assign lane_bit = lane_big;

  // general registers; index zero has no storage at all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 1; i < CPM_NREG; i++) begin
        regs_q[i] <= CPM_WORD_RESET;
      end
    end else begin
      if (wr_en && wr_sel != CPM_ZERO_REG && !fault) begin
        regs_q[wr_sel] <= wr_data;
      end
      if (link_en) begin
        regs_q[CPM_LINK_REG] <= link_addr;
      end
    end
  end

  function automatic logic [31:0] gpr_read(input logic [4:0] sel);
    gpr_read = (sel == CPM_ZERO_REG) ? CPM_WORD_RESET : regs_q[sel];
  endfunction

  assign rd_a_data = gpr_read(rd_a_sel);
  assign rd_b_data = gpr_read(rd_b_sel);

  // result pair; a full product or quotient/remainder lands in one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= CPM_WORD_RESET;
      lo_q <= CPM_WORD_RESET;
    end else if (muldiv_en) begin
      hi_q <= muldiv_upper;
      lo_q <= muldiv_lower;
    end else begin
      if (result_upper_wr) hi_q <= wr_data;
      if (result_lower_wr) lo_q <= wr_data;
    end
  end
  assign result_upper = hi_q;
  assign result_lower = lo_q;

  // access checks
  assign sz = cpm_size_e'(mem_size);
  assign off = mem_addr[1:0];
  always_comb begin
    unique case (sz)
      CPM_SZ_HALF: misaligned = off[0];
      CPM_SZ_WORD: misaligned = (off != 2'h0);
      default: misaligned = 1'b0;
    endcase
  end
  assign seg_fault = mem_req && user_cur && mem_addr[CPM_SEG_BIT];
  assign cop_fault = cop_req && user_cur && !sr_q[CPM_SR_CU_LO + cop_sel];
  assign fault = (mem_req && misaligned) || seg_fault || cop_fault;
  assign exc_raise = fault;
  assign exc_raise_code = cop_fault ? CPM_EXC_COP_UNUSABLE :
                          (mem_store ? CPM_EXC_ADDR_STORE : CPM_EXC_ADDR_LOAD);
  assign mem_go = mem_req && !fault;

  // physical lane index of a byte at offset k within the word
  function automatic logic [1:0] lane_of(input logic [1:0] k, input logic big);
    lane_of = big ? (2'h3 - k) : k;
  endfunction

  // lane steering for all sizes; the address names the msb in big order
  always_comb begin
    logic [1:0] ln;
    logic [7:0] b;
    logic [1:0] dst;
    dst = 2'h0;
    mem_lanes = 4'h0;
    mem_store_word = CPM_WORD_RESET;
    mem_load_result = mem_load_old;
    ln = lane_of(off, lane_bit);
    b = mem_load_word[8*ln +: 8];
    unique case (sz)
      CPM_SZ_BYTE: begin
        mem_lanes[ln] = 1'b1;
        mem_store_word[8*ln +: 8] = mem_store_reg[7:0];
        mem_load_result = {24'h000000, b};
      end
      CPM_SZ_HALF: begin
        // half at offset 0 or 2 occupies two lanes
        if (lane_bit == (off[1] == 1'b0)) begin
          mem_lanes[3:2] = 2'h3;
          mem_store_word[31:16] = mem_store_reg[15:0];
          mem_load_result = {16'h0000, mem_load_word[31:16]};
        end else begin
          mem_lanes[1:0] = 2'h3;
          mem_store_word[15:0] = mem_store_reg[15:0];
          mem_load_result = {16'h0000, mem_load_word[15:0]};
        end
      end
      CPM_SZ_WORD: begin
        mem_lanes = 4'hF;
        mem_store_word = mem_store_reg;
        mem_load_result = mem_load_word;
      end
      CPM_SZ_PART_HIGH: begin
        // move bytes from the addressed one to the word's far end
        for (int k = 0; k < 4; k++) begin
          if (k[1:0] >= off) begin
            dst = 2'h3 - (k[1:0] - off);
            mem_lanes[lane_of(k[1:0], lane_bit)] = 1'b1;
            mem_store_word[8*lane_of(k[1:0], lane_bit) +: 8] = mem_store_reg[8*dst +: 8];
            mem_load_result[8*dst +: 8] = mem_load_word[8*lane_of(k[1:0], lane_bit) +: 8];
          end
        end
      end
      CPM_SZ_PART_LOW: begin
        // the companion: bytes from the word's start to the addressed one
        for (int k = 0; k < 4; k++) begin
          if (k[1:0] <= off) begin
            dst = off - k[1:0];
            mem_lanes[lane_of(k[1:0], lane_bit)] = 1'b1;
            mem_store_word[8*lane_of(k[1:0], lane_bit) +: 8] = mem_store_reg[8*dst +: 8];
            mem_load_result[8*dst +: 8] = mem_load_word[8*lane_of(k[1:0], lane_bit) +: 8];
          end
        end
      end
      default: mem_lanes = 4'h0;
    endcase
    if (fault) mem_lanes = 4'h0;
  end

  // pseudo-random pointer steps down each cycle and wraps in its range
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rand_q <= CPM_RAND_TOP;
    end else if (rand_q == CPM_RAND_BOT) begin
      rand_q <= CPM_RAND_TOP;
    end else begin
      rand_q <= rand_q - 6'h01;
    end
  end

  function automatic logic sc_is_reserved(input logic [4:0] n);
    unique case (n)
      CPM_SC_TLB_PTR_PROG, CPM_SC_TLB_PTR_RAND, CPM_SC_TLB_LO, CPM_SC_PAGE_TBL,
      CPM_SC_FAULT_VA, CPM_SC_TLB_HI, CPM_SC_STATE_CTRL, CPM_SC_EXC_REASON,
      CPM_SC_EXC_PC, CPM_SC_REV_ID: sc_is_reserved = 1'b0;
      CPM_SC_HW_OPTIONS: sc_is_reserved = !HAS_FPU;
      default: sc_is_reserved = 1'b1;
    endcase
  endfunction

  logic sc_ok;
  // moves from user mode need coprocessor zero usable
  assign sc_ok = !sc_is_reserved(sc_sel) && (!user_cur || sr_q[CPM_SR_CU_LO]);
  assign sc_reserved = (sc_rd || sc_wr) && sc_is_reserved(sc_sel);

  // writable system control registers; read-only ones ignore writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tlb_prog_q <= CPM_WORD_RESET;
      tlb_lo_q <= CPM_WORD_RESET;
      tlb_hi_q <= CPM_WORD_RESET;
      hwopt_q <= CPM_WORD_RESET;
      page_tbl_q <= CPM_WORD_RESET;
    end else if (sc_wr && sc_ok && !fault) begin
      unique case (sc_sel)
        CPM_SC_TLB_PTR_PROG: tlb_prog_q <= sc_wdata;
        CPM_SC_TLB_LO: tlb_lo_q <= sc_wdata;
        CPM_SC_HW_OPTIONS: hwopt_q <= sc_wdata;
        CPM_SC_PAGE_TBL: page_tbl_q <= sc_wdata;
        CPM_SC_TLB_HI: tlb_hi_q <= sc_wdata;
        default: tlb_prog_q <= tlb_prog_q;
      endcase
    end
  end

  // mode stack and exception capture; exception beats every other write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_q <= CPM_SR_RESET;
      reason_q <= CPM_WORD_RESET;
      epc_q <= CPM_WORD_RESET;
      fault_va_q <= CPM_WORD_RESET;
    end else if (exc_in || fault) begin
      // push the mode/interrupt pairs, current becomes kernel
      sr_q[5:0] <= {sr_q[3:0], 2'b00};
      reason_q[CPM_EXC_CODE_LO +: 5] <= fault ? exc_raise_code : exc_code_in;
      epc_q <= exc_pc;
      if (fault && !cop_fault) fault_va_q <= mem_addr;
    end else if (return_from_exception) begin
      sr_q[3:0] <= sr_q[5:2];
    end else if (sc_wr && sc_ok && sc_sel == CPM_SC_STATE_CTRL) begin
      sr_q <= sc_wdata;
    end else if (sc_wr && sc_ok && sc_sel == CPM_SC_EXC_REASON) begin
      reason_q[9:8] <= sc_wdata[9:8]; // only the software bits are writable
    end
  end

  // read mux; reserved numbers read as zero
  always_comb begin
    sc_rdata = CPM_WORD_RESET;
    if (sc_rd && sc_ok) begin
      unique case (sc_sel)
        CPM_SC_TLB_PTR_PROG: sc_rdata = tlb_prog_q;
        CPM_SC_TLB_PTR_RAND: sc_rdata = {18'h00000, rand_q, 8'h00};
        CPM_SC_TLB_LO: sc_rdata = tlb_lo_q;
        CPM_SC_HW_OPTIONS: sc_rdata = hwopt_q;
        CPM_SC_PAGE_TBL: sc_rdata = page_tbl_q;
        CPM_SC_FAULT_VA: sc_rdata = fault_va_q;
        CPM_SC_TLB_HI: sc_rdata = tlb_hi_q;
        CPM_SC_STATE_CTRL: sc_rdata = sr_q;
        CPM_SC_EXC_REASON: sc_rdata = reason_q;
        CPM_SC_EXC_PC: sc_rdata = epc_q;
        CPM_SC_REV_ID: sc_rdata = REV_ID;
        default: sc_rdata = CPM_WORD_RESET;
      endcase
    end
  end

endmodule

/* tb/cpm_state_sva.sv */
// Purpose: port-level checker for the programming-model state block
// Assumes: one clock domain, reset asynchronous and active low
// Notes: lane checks cover byte and word sizes only
`timescale 1ns/1ps
module cpm_state_sva
  import cpm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register and result ports
  input wire logic [4:0] rd_a_sel,
  input wire logic [31:0] rd_a_data,
  input wire logic muldiv_en,
  input wire logic [31:0] muldiv_upper,
  input wire logic [31:0] muldiv_lower,
  input wire logic [31:0] result_upper,
  input wire logic [31:0] result_lower,
  // memory access
  input wire logic mem_req,
  input wire logic [2:0] mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic mem_go,
  input wire logic [3:0] mem_lanes,
  // control moves and modes
  input wire logic sc_wr,
  input wire logic sc_rd,
  input wire logic [4:0] sc_sel,
  input wire logic sc_reserved,
  input wire logic exc_in,
  input wire logic return_from_exception,
  input wire logic exc_raise,
  input wire logic kernel_mode,
  input wire logic big_endian_now
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // data-path and mode relations, all same-cycle except the result pair and the two mode checks
  zero_reg_a: assert property (rd_a_sel == 5'h00 |-> rd_a_data == 32'h0)
    else $error("zero register read nonzero");
  word_lanes_a: assert property (mem_req && mem_size == 3'h2 && mem_addr[1:0] == 2'h0
    && !exc_raise |-> mem_lanes == 4'hF)
    else $error("aligned word did not enable all lanes");
  misalign_a: assert property (mem_req && ((mem_size == 3'h2 && mem_addr[1:0] != 2'h0)
    || (mem_size == 3'h1 && mem_addr[0])) |-> exc_raise)
    else $error("misaligned access not faulted");
  big_byte0_a: assert property (mem_req && mem_size == 3'h0 && mem_addr[1:0] == 2'h0
    && big_endian_now && !exc_raise |-> mem_lanes == 4'h8)
    else $error("big order byte zero on wrong lane");
  little_byte0_a: assert property (mem_req && mem_size == 3'h0 && mem_addr[1:0] == 2'h0
    && !big_endian_now && !exc_raise |-> mem_lanes == 4'h1)
    else $error("little order byte zero on wrong lane");
  fault_blocks_a: assert property (mem_req && exc_raise |-> !mem_go)
    else $error("faulted access allowed to go");
  result_pair_a: assert property (muldiv_en |=> result_upper == $past(muldiv_upper)
    && result_lower == $past(muldiv_lower))
    else $error("result pair not loaded");
  reserved_sel_a: assert property ((sc_wr || sc_rd) && (sc_sel[4]
    || sc_sel inside {5'h05, 5'h06, 5'h07, 5'h09, 5'h0B}) |-> sc_reserved)
    else $error("reserved control number not flagged");
  exc_kernel_a: assert property (exc_in |=> kernel_mode)
    else $error("exception did not enter kernel mode");
  mode_hold_a: assert property (!exc_in && !return_from_exception && !sc_wr && !exc_raise
    |=> $stable(kernel_mode))
    else $error("mode changed without cause");
endmodule

bind cpm_state cpm_state_sva i_cpm_state_sva (.clk, .rst_n, .rd_a_sel, .rd_a_data,
  .muldiv_en, .muldiv_upper, .muldiv_lower, .result_upper, .result_lower, .mem_req,
  .mem_size, .mem_addr, .mem_go, .mem_lanes, .sc_wr, .sc_rd, .sc_sel, .sc_reserved,
  .exc_in, .return_from_exception, .exc_raise, .kernel_mode, .big_endian_now);

/* tb/cpm_state_tb_top.sv */
// Purpose: self-checking bench for the programming-model state block
// Assumes: reads and lane steering are combinational, writes land at the edge
// Notes: store data and partial-word merging are not compared here
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpm_state_tb_top import cpm_pkg::*;;
  typedef struct packed {logic [2:0] sz; logic [1:0] off; logic exc; logic [3:0] lanes;
    logic [31:0] res;} cpm_row_s;
  logic clk = 1'b0, rst_n = 1'b0, big_endian_strap = 1'b1, wr_en = 1'b0, link_en = 1'b0;
  logic muldiv_en = 1'b0, result_upper_wr = 1'b0, result_lower_wr = 1'b0, mem_req = 1'b0;
  logic mem_store = 1'b0, cop_req = 1'b0, sc_wr = 1'b0, sc_rd = 1'b0, exc_in = 1'b0;
  logic return_from_exception = 1'b0;
  logic [1:0] cop_sel = 2'h0;
  logic [2:0] mem_size = 3'h0;
  logic [4:0] rd_a_sel = 5'h00, rd_b_sel = 5'h00, wr_sel = 5'h00, sc_sel = 5'h00;
  logic [4:0] exc_code_in = 5'h00;
  logic [31:0] wr_data = 32'h0, link_addr = 32'h0, muldiv_upper = 32'h0, muldiv_lower = 32'h0;
  logic [31:0] mem_addr = 32'h0, sc_wdata = 32'h0, exc_pc = 32'h0;
  logic [31:0] mem_load_word = 32'h1122_3344;
  wire logic [31:0] rd_a_data, rd_b_data, result_upper, result_lower, mem_load_result, sc_rdata;
  wire logic mem_go, sc_reserved, exc_raise, kernel_mode, big_endian_now;
  wire logic [3:0] mem_lanes;
  wire logic [4:0] exc_raise_code;
  int bad_count = 0, cmp_count = 0;
  // big-order cases on a word holding 11 22 33 44, faults last
  cpm_row_s rows [8] = '{'{3'h0, 2'h0, 1'b0, 4'h8, 32'h11}, '{3'h0, 2'h1, 1'b0, 4'h4, 32'h22},
    '{3'h0, 2'h3, 1'b0, 4'h1, 32'h44}, '{3'h1, 2'h0, 1'b0, 4'hC, 32'h1122},
    '{3'h1, 2'h2, 1'b0, 4'h3, 32'h3344}, '{3'h2, 2'h0, 1'b0, 4'hF, 32'h1122_3344},
    '{3'h1, 2'h1, 1'b1, 4'h0, 32'h0}, '{3'h2, 2'h2, 1'b1, 4'h0, 32'h0}};

  cpm_state i_cpm_state (.clk, .rst_n, .big_endian_strap, .rd_a_sel, .rd_b_sel, .rd_a_data,
    .rd_b_data, .wr_en, .wr_sel, .wr_data, .link_en, .link_addr, .muldiv_en, .muldiv_upper,
    .muldiv_lower, .result_upper_wr, .result_lower_wr, .result_upper, .result_lower,
    .mem_req, .mem_store, .mem_size, .mem_addr, .mem_store_reg(32'h0), .mem_load_word,
    .mem_load_old(32'h0), .mem_go, .mem_lanes, .mem_store_word(), .mem_load_result,
    .cop_sel, .cop_req, .sc_wr, .sc_rd, .sc_sel, .sc_wdata, .sc_rdata, .sc_reserved,
    .exc_in, .exc_code_in, .exc_pc, .return_from_exception, .exc_raise, .exc_raise_code,
    .kernel_mode, .big_endian_now);

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // strap must stay put through the first edge after release
  task automatic do_reset(input logic be);
    rst_n <= 1'b0;
    big_endian_strap <= be;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  // one-cycle strobe pulses, checked at the following falling edge
  task automatic reg_wr(input logic [4:0] s, input logic [31:0] d, input logic lk);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_data <= d;
    link_en <= lk;
    link_addr <= ~d;
    @(posedge clk);
    wr_en <= 1'b0;
    link_en <= 1'b0;
    rd_a_sel <= s;
    rd_b_sel <= s;
    @(negedge clk);
  endtask

  task automatic sc_move(input logic w, input logic [4:0] s, input logic [31:0] d);
    @(posedge clk);
    mem_req <= 1'b0;
    cop_req <= 1'b0;
    sc_wr <= w;
    sc_rd <= ~w;
    sc_sel <= s;
    sc_wdata <= d;
    @(negedge clk);
    @(posedge clk);
    sc_wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic mem_try(input logic [2:0] s, input logic [31:0] a, input logic cp);
    @(posedge clk);
    mem_req <= ~cp;
    cop_req <= cp;
    cop_sel <= 2'h1;
    mem_size <= s;
    mem_addr <= a;
    @(negedge clk);
  endtask

  task automatic pulse_exc(input logic rf);
    @(posedge clk);
    mem_req <= 1'b0;
    cop_req <= 1'b0;
    exc_in <= ~rf;
    return_from_exception <= rf;
    exc_pc <= 32'h0000_1230;
    @(posedge clk);
    exc_in <= 1'b0;
    return_from_exception <= 1'b0;
    @(negedge clk);
  endtask

  // guard against a hang; the whole run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    do_reset(1'b1);
    `CHK({kernel_mode, big_endian_now}, 2'b11)
    sc_move(1'b0, CPM_SC_REV_ID, 32'h0);
    `CHK(sc_rdata, 32'h0000_0A5A)
    `CHK(sc_reserved, 1'b0)
    foreach (rows[i]) begin
      mem_try(rows[i].sz, {30'h0, rows[i].off}, 1'b0);
      `CHK(exc_raise, rows[i].exc)
      if (!rows[i].exc) begin
        `CHK(mem_lanes, rows[i].lanes)
        `CHK(mem_load_result, rows[i].res)
      end
    end
    mem_try(3'h0, 32'h0, 1'b1);
    // every register holds its own pattern, except the zero register
    for (int i = 0; i < 32; i++) begin
      reg_wr(5'(i), {27'h4D2_0000, 5'(i)}, 1'b0);
      `CHK(rd_b_data, (i == 0) ? 32'h0 : {27'h4D2_0000, 5'(i)})
    end
    reg_wr(CPM_LINK_REG, 32'h0000_00F0, 1'b1);
    `CHK(rd_a_data, 32'hFFFF_FF0F)
    @(posedge clk);
    muldiv_en <= 1'b1;
    muldiv_upper <= 32'h89AB_CDEF;
    muldiv_lower <= 32'h0123_4567;
    @(posedge clk);
    muldiv_en <= 1'b0;
    @(negedge clk);
    `CHK({result_upper, result_lower}, 64'h89AB_CDEF_0123_4567)
    // kernel drops to user with reversed order and no coprocessor use
    sc_move(1'b1, CPM_SC_HW_OPTIONS, 32'h0000_00A5);
    sc_move(1'b0, CPM_SC_HW_OPTIONS, 32'h0);
    `CHK(sc_rdata, 32'h0000_00A5)
    sc_move(1'b1, CPM_SC_STATE_CTRL, 32'h0200_0002);
    `CHK({kernel_mode, big_endian_now}, 2'b00)
    // every fault is taken as an exception at the next edge; the return re-enters user mode
    mem_try(3'h2, 32'h0000_0100, 1'b0);
    `CHK({exc_raise, mem_go}, 2'b01)
    mem_try(3'h0, 32'h0000_0100, 1'b1);
    `CHK({exc_raise, exc_raise_code}, {1'b1, CPM_EXC_COP_UNUSABLE})
    pulse_exc(1'b1);
    `CHK(kernel_mode, 1'b0)
    mem_try(3'h2, 32'h8000_0000, 1'b0);
    `CHK({exc_raise, mem_go, exc_raise_code}, {2'b10, CPM_EXC_ADDR_LOAD})
    pulse_exc(1'b0);
    `CHK({kernel_mode, big_endian_now}, 2'b11)
    sc_move(1'b0, CPM_SC_EXC_PC, 32'h0);
    `CHK(sc_rdata, 32'h0000_1230)
    // two nested exceptions: first return stays kernel, second back to user
    pulse_exc(1'b1);
    `CHK(kernel_mode, 1'b1)
    pulse_exc(1'b1);
    `CHK(kernel_mode, 1'b0)
    do_reset(1'b0);
    mem_try(3'h0, 32'h0, 1'b0);
    `CHK({mem_lanes, mem_load_result}, {4'h1, 32'h44})
    stop_test();
  end
endmodule
